// >>> testbench/flow_partner.sv
// flow_partner: behavioural stack ram and program memory for the flow unit.
// assumes one core clock; read data is valid the cycle after its request.
`timescale 1ns/10ps
module flow_partner
  import flow_pkg::*;
(
  input wire logic sys_clk_in,              // core clock
  input wire logic stack_we_in,             // stack write pulse
  input wire logic stack_re_in,             // stack read pulse
  input wire logic [7:0] stack_addr_in,     // stack address
  input wire logic [7:0] stack_wdata_in,    // stack write data
  input wire flow_pkg::mem_req_type code_req_in, // code address
  output logic [7:0] stack_rdata_out,       // stack read data
  output logic [7:0] code_rdata_out         // code read data
);
  logic [7:0] mem [0:255];

  initial begin
    stack_rdata_out = 8'h00;
    code_rdata_out = 8'h00;
  end

  // ==========================================================
  // stack ram
  // idle data toggles so a late sample never looks valid
  always @(posedge sys_clk_in) begin
    if (stack_we_in === 1'b1)
      mem[stack_addr_in] <= stack_wdata_in;
    if (stack_re_in === 1'b1)
      stack_rdata_out <= mem[stack_addr_in];
    else
      stack_rdata_out <= ~stack_rdata_out;
  end

  // ==========================================================
  // program memory, contents derived from the address
  always @(posedge sys_clk_in) begin
    if (code_req_in.valid === 1'b1)
      code_rdata_out <= code_req_in.addr[7:0] ^ code_req_in.addr[15:8] ^ 8'h5a;
    else
      code_rdata_out <= ~code_rdata_out;
  end
endmodule

// >>> testbench/tb_top.sv
// tb_top: directed scenarios for the program-flow address unit.
// assumes the partner model answers the stack and code requests of the unit; external data requests are left unanswered.
`timescale 1ns/10ps
module tb_top;
  import flow_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  req_type req;
  logic [7:0] s_rd, c_rd, s_addr, s_wd, sp, acc;
  logic s_we, s_re, acc_v, busy;
  logic [15:0] pc, caddr;
  mem_req_type creq, xreq;
  int n_errors = 0;
  int num_checks = 0;

  always #4 clk = ~clk;

  program_flow_address_unit uut (.sys_clk_in(clk), .sys_rst_in(rst), .req_in(req),
    .stack_rdata_in(s_rd), .code_rdata_in(c_rd), .code_req_out(creq),
    .xdata_req_out(xreq), .stack_we_out(s_we), .stack_re_out(s_re),
    .stack_addr_out(s_addr), .stack_wdata_out(s_wd), .pc_out(pc),
    .stack_pointer_out(sp), .acc_out(acc), .acc_valid_out(acc_v), .busy_out(busy));

  flow_partner pt (.sys_clk_in(clk), .stack_we_in(s_we), .stack_re_in(s_re),
    .stack_addr_in(s_addr), .stack_wdata_in(s_wd), .code_req_in(creq),
    .stack_rdata_out(s_rd), .code_rdata_out(c_rd));

  // last code address seen on the memory side
  always @(posedge clk) begin
    if (creq.valid === 1'b1) caddr <= creq.addr;
  end

  // ==========================================================
  // helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // one request for one cycle, then op none while the unit sequences
  task automatic issue(input op_type op, input logic [7:0] a, input logic [15:0] dp,
                       input logic [15:0] tg, input logic [7:0] p8, input logic [1:0] ln);
    @(negedge clk);
    req = '{op: op, acc: a, data_pointer: dp, target: tg, ptr8: p8, len: ln};
    @(negedge clk);
    req.op = OP_NONE;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_jumps();
    issue(OP_INDIRECT_JUMP, 8'hf0, 16'h1220, 16'h0000, 8'h00, 2'h1);
    chk(pc, 16'h1310);
    issue(OP_INDIRECT_JUMP, 8'hfe, 16'h0700, 16'h0000, 8'h00, 2'h1);
    chk(pc, 16'h07fe);
    // incremented pc crosses into the next 2K page
    issue(OP_IN_PAGE_JUMP, 8'h00, 16'h0000, 16'h0123, 8'h00, 2'h2);
    chk(pc, 16'h0923);
    $display("test jumps done");
  endtask

  task automatic t_calls();
    issue(OP_LONG_CALL, 8'h00, 16'h0000, 16'h4000, 8'h00, 2'h3);
    chk({15'h0000, busy}, 16'h0001);
    repeat (4) @(negedge clk);
    chk(pc, 16'h4000);
    chk({15'h0000, busy}, 16'h0000);
    chk({8'h00, sp}, 16'h0009);
    chk({pt.mem[8'h09], pt.mem[8'h08]}, 16'h0926);
    issue(OP_IN_PAGE_CALL, 8'h00, 16'h0000, 16'h0055, 8'h00, 2'h2);
    repeat (4) @(negedge clk);
    chk(pc, 16'h4055);
    chk({pt.mem[8'h0b], pt.mem[8'h0a]}, 16'h4002);
    issue(OP_RETURN, 8'h00, 16'h0000, 16'h0000, 8'h00, 2'h1);
    repeat (5) @(negedge clk);
    chk(pc, 16'h4002);
    chk({8'h00, sp}, 16'h0009);
    issue(OP_RETURN, 8'h00, 16'h0000, 16'h0000, 8'h00, 2'h1);
    repeat (5) @(negedge clk);
    chk(pc, 16'h0926);
    chk({8'h00, sp}, 16'h0007);
    $display("test calls done");
  endtask

  task automatic tread(input logic [7:0] a, input logic [15:0] dp, input logic [15:0] ea);
    int i;
    issue(OP_CODE_TABLE_READ, a, dp, 16'h0000, 8'h00, 2'h1);
    for (i = 0; i < 10 && acc_v !== 1'b1; i++)
      @(negedge clk);
    if (i == 10) begin
      $display("unexpected at %0t: acc_valid %h exp %h", $time, acc_v, 1'b1);
      n_errors++;
      summarize();
    end
    chk(caddr, ea);
    chk({8'h00, acc}, {8'h00, ea[7:0] ^ ea[15:8] ^ 8'h5a});
    repeat (2) @(negedge clk);
  endtask

  task automatic t_xdata();
    // the request stands one cycle only, so it is looked at straight away
    issue(OP_XDATA_READ_8, 8'h00, 16'habcd, 16'h0000, 8'hc3, 2'h1);
    chk({15'h0000, xreq.valid}, 16'h0001);
    chk(xreq.addr, 16'h00c3);
    issue(OP_XDATA_READ_16, 8'h00, 16'habcd, 16'h0000, 8'hc3, 2'h1);
    chk({15'h0000, xreq.valid}, 16'h0001);
    chk(xreq.addr, 16'habcd);
    $display("test xdata done");
  endtask

  // jump leaves the last table byte alone, then fetch runs from the target
  task automatic t_fetch();
    issue(OP_INDIRECT_JUMP, 8'h00, 16'h2000, 16'h0000, 8'h00, 2'h1);
    chk(pc, 16'h2000);
    chk({8'h00, acc}, 16'h005b);
    chk({15'h0000, acc_v}, 16'h0000);
    issue(OP_FETCH, 8'h00, 16'h0000, 16'h0000, 8'h00, 2'h1);
    chk({15'h0000, creq.valid}, 16'h0001);
    chk(creq.addr, 16'h2000);
    chk(pc, 16'h2001);
    $display("test fetch done");
  endtask

  initial begin
    req = '{op: OP_NONE, acc: 8'h00, data_pointer: 16'h0000, target: 16'h0000,
            ptr8: 8'h00, len: 2'h1};
    repeat (10) @(negedge clk);
    chk(pc, 16'h0000);
    chk({8'h00, sp}, 16'h0007);
    rst = 1'b0;
    t_jumps();
    t_calls();
    tread(8'hff, 16'hff00, 16'hffff);
    tread(8'h01, 16'h00ff, 16'h0100);
    $display("test table read done");
    t_xdata();
    t_fetch();
    summarize();
  end
endmodule

// >>> verilog/addr_adder.sv
// addr_adder: unsigned 8-bit plus 16-bit address sum.
// assumes combinational use inside the flow unit.
`timescale 1ns/10ps
module addr_adder (
  input wire logic [7:0] acc_in,           // accumulator, unsigned
  input wire logic [15:0] data_pointer_in, // base pointer
  output logic [15:0] sum_out              // full 16-bit sum
);
  import flow_pkg::*;
  // carry out of the low byte ripples upward; see RULE3
  assign sum_out = data_pointer_in + {8'h00, acc_in};
endmodule

// >>> verilog/flow_pkg.sv
// flow_pkg: shared constants and carriers for the program-flow address unit.
// assumes a single core clock; no software-visible registers.
package flow_pkg;
  // ==========================================================
  // widths
  localparam int ADDR_W = 16;
  localparam int BYTE_W = 8;
  localparam int PAGE_BITS = 11;
  localparam int SP_W = 8;
  // ==========================================================
  // reset values
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] SP_RESET = 8'h07;
  // ==========================================================
  // operations presented by the sequencer
  typedef enum logic [3:0] {
    OP_NONE,
    OP_FETCH,
    OP_INDIRECT_JUMP,
    OP_CODE_TABLE_READ,
    OP_IN_PAGE_CALL,
    OP_LONG_CALL,
    OP_RETURN,
    OP_IN_PAGE_JUMP,
    OP_XDATA_READ_8,
    OP_XDATA_READ_16
  } op_type;

  typedef struct packed {
    op_type op;
    logic [7:0] acc;
    logic [15:0] data_pointer;
    logic [15:0] target;  // long call target, or 11-bit field in low bits
    logic [7:0] ptr8;
    logic [1:0] len;      // instruction length in bytes
  } req_type;

  typedef struct packed {
    logic valid;
    logic [15:0] addr;
  } mem_req_type;
endpackage

// >>> verilog/program_flow_address_unit.sv
// program_flow_address_unit: pc, stack and data address sequencing of the core.
// assumes one request at a time while busy_out is low; stack ram and memories are
// synchronous, read data valid the cycle after the request.
// Contract
// RULE1: indirect jump and table read form accumulator plus data pointer, unsigned.
// RULE2: indirect jump loads the sum into pc; fetches follow from it.
// RULE3: the sum is a full 16-bit add with carry into the high byte.
// RULE4: accumulator and data pointer are left unchanged by the indirect jump.
// RULE5: table read reaches all 64K code bytes, result to accumulator.
// RULE6: both calls push the address of the byte after the call.
// RULE7: return address pushed low byte first; return pops two bytes, restores sp.
// RULE8: in-page jump is two bytes and reaches only the same 2K page.
// RULE9: external read via 8-bit pointer drives only an 8-bit address.
// RULE10: external read via data pointer drives the full 16-bit address.
// RULE11: stack grows upward; pre-increment on push, post-decrement on pop.
// RULE12: in-page jump replaces low 11 bits of incremented pc, keeps upper 5.
`timescale 1ns/10ps
module program_flow_address_unit (
  input wire logic sys_clk_in,                  // core clock 125 MHz
  input wire logic sys_rst_in,                  // async reset, active high
  input wire flow_pkg::req_type req_in,         // operation request
  input wire logic [7:0] stack_rdata_in,        // stack ram read data
  input wire logic [7:0] code_rdata_in,         // program memory read data
  output flow_pkg::mem_req_type code_req_out,   // program memory address
  output flow_pkg::mem_req_type xdata_req_out,  // external data address
  output logic stack_we_out,                    // stack ram write
  output logic stack_re_out,                    // stack ram read
  output logic [7:0] stack_addr_out,            // stack ram address
  output logic [7:0] stack_wdata_out,           // stack ram write data
  output logic [15:0] pc_out,                   // program counter
  output logic [7:0] stack_pointer_out,         // stack pointer
  output logic [7:0] acc_out,                   // accumulator result
  output logic acc_valid_out,                   // acc_out updated, pulse
  output logic busy_out                         // multi-cycle op in progress
);
  import flow_pkg::*;

  // ==========================================================
  // state
  // nine states, so the code needs four bits
  typedef enum logic [3:0] {
    ST_IDLE, ST_PUSH_LO, ST_PUSH_HI,
    ST_POP_HI, ST_POP_LO, ST_POP_DONE, ST_POP_LOAD,
    ST_TABLE, ST_TABLE_DATA
  } state_type;

  state_type state_r;
  logic [15:0] pc_r;
  logic [7:0] sp_r;
  logic [15:0] ret_addr_r;
  logic [15:0] call_target_r;
  logic [7:0] pop_hi_r;
  logic [15:0] sum;
  logic [15:0] next_pc;
  logic [15:0] page_target;

  addr_adder u_adder (
    .acc_in(req_in.acc),                  // see RULE1
    .data_pointer_in(req_in.data_pointer),
    .sum_out(sum)
  );

  assign next_pc = pc_r + {14'h0000, req_in.len};
  // upper 5 bits come from the incremented pc; see RULE12
  assign page_target = {next_pc[ADDR_W-1:PAGE_BITS], req_in.target[PAGE_BITS-1:0]};

  wire idle_go = (state_r == ST_IDLE);

  // ==========================================================
  // sequencer
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          case (req_in.op)
            OP_IN_PAGE_CALL, OP_LONG_CALL: state_r <= ST_PUSH_LO;
            OP_RETURN: state_r <= ST_POP_HI;
            OP_CODE_TABLE_READ: state_r <= ST_TABLE;
            default: state_r <= ST_IDLE;
          endcase
        end
        ST_PUSH_LO: state_r <= ST_PUSH_HI;
        ST_PUSH_HI: state_r <= ST_IDLE;
        ST_POP_HI: state_r <= ST_POP_LO;
        ST_POP_LO: state_r <= ST_POP_DONE;
        // memory answers a cycle after the port pulse, so reads need a wait state
        ST_POP_DONE: state_r <= ST_POP_LOAD;
        ST_POP_LOAD: state_r <= ST_IDLE;
        ST_TABLE: state_r <= ST_TABLE_DATA;
        ST_TABLE_DATA: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // program counter
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pc_r <= PC_RESET;
    end else if (idle_go) begin
      case (req_in.op)
        OP_INDIRECT_JUMP: pc_r <= sum;             // see RULE2
        OP_IN_PAGE_JUMP: pc_r <= page_target;      // see RULE8
        OP_FETCH, OP_CODE_TABLE_READ, OP_XDATA_READ_8, OP_XDATA_READ_16: pc_r <= next_pc;
        default: pc_r <= pc_r;
      endcase
    end else if (state_r == ST_PUSH_HI) begin
      pc_r <= call_target_r;                       // transfer together with the second push
    end else if (state_r == ST_POP_LOAD) begin
      // low byte is on the read port now, high byte was held a cycle earlier
      pc_r <= {pop_hi_r, stack_rdata_in};          // see RULE7
    end
  end

  // ==========================================================
  // call bookkeeping
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ret_addr_r <= 16'h0000;
      call_target_r <= 16'h0000;
    end else if (idle_go && (req_in.op == OP_IN_PAGE_CALL || req_in.op == OP_LONG_CALL)) begin
      ret_addr_r <= next_pc;                       // see RULE6
      call_target_r <= (req_in.op == OP_IN_PAGE_CALL) ? page_target : req_in.target;
    end
  end

  // ==========================================================
  // stack pointer and stack ram port
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sp_r <= SP_RESET;
      stack_we_out <= 1'b0;
      stack_re_out <= 1'b0;
      stack_addr_out <= 8'h00;
      stack_wdata_out <= 8'h00;
      pop_hi_r <= 8'h00;
    end else begin
      stack_we_out <= 1'b0;
      stack_re_out <= 1'b0;
      case (state_r)
        ST_PUSH_LO, ST_PUSH_HI: begin
          // pre-increment then write, low byte first; see RULE11
          sp_r <= sp_r + 8'h01;
          stack_we_out <= 1'b1;
          stack_addr_out <= sp_r + 8'h01;
          stack_wdata_out <= (state_r == ST_PUSH_LO) ? ret_addr_r[7:0] : ret_addr_r[15:8];
        end
        ST_POP_HI, ST_POP_LO: begin
          // read at sp then decrement; see RULE11
          sp_r <= sp_r - 8'h01;
          stack_re_out <= 1'b1;
          stack_addr_out <= sp_r;
        end
        ST_POP_DONE: begin
          // first read, at the old top, carries the high byte; see RULE7
          pop_hi_r <= stack_rdata_in;
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // memory address outputs
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      code_req_out <= '0;
      xdata_req_out <= '0;
    end else begin
      code_req_out.valid <= 1'b0;
      xdata_req_out.valid <= 1'b0;
      if (idle_go) begin
        case (req_in.op)
          OP_FETCH: begin
            code_req_out.valid <= 1'b1;
            code_req_out.addr <= pc_r;
          end
          OP_CODE_TABLE_READ: begin
            code_req_out.valid <= 1'b1;
            code_req_out.addr <= sum;              // see RULE5
          end
          OP_XDATA_READ_8: begin
            xdata_req_out.valid <= 1'b1;
            xdata_req_out.addr <= {8'h00, req_in.ptr8};  // see RULE9
          end
          OP_XDATA_READ_16: begin
            xdata_req_out.valid <= 1'b1;
            xdata_req_out.addr <= req_in.data_pointer;   // see RULE10
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ==========================================================
  // accumulator result; indirect jump never writes it (see RULE4)
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      acc_out <= 8'h00;
      acc_valid_out <= 1'b0;
    end else begin
      // byte answers the address of the previous cycle; see RULE5
      acc_valid_out <= (state_r == ST_TABLE_DATA);
      if (state_r == ST_TABLE_DATA) begin
        acc_out <= code_rdata_in;                  // see RULE5
      end
    end
  end

  // ==========================================================
  // busy flag
  // low again in the cycle in which the sequencer is back in idle
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      busy_out <= 1'b0;
    end else begin
      busy_out <= !(state_r == ST_IDLE && req_in.op != OP_IN_PAGE_CALL &&
                    req_in.op != OP_LONG_CALL && req_in.op != OP_RETURN &&
                    req_in.op != OP_CODE_TABLE_READ) && state_r != ST_PUSH_HI &&
                  state_r != ST_POP_LOAD && state_r != ST_TABLE_DATA;
    end
  end

  assign pc_out = pc_r;
  assign stack_pointer_out = sp_r;

  // ==========================================================
  // assertions
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);

  // expected addresses are rebuilt from the request or the pc, never read back from the adder
  indirect_jump_a: assert property (idle_go && req_in.op == OP_INDIRECT_JUMP |=> // see RULE2
    pc_r == $past(req_in.data_pointer) + {8'h00, $past(req_in.acc)})
    else $error("indirect jump target wrong");
  fetch_a: assert property (idle_go && req_in.op == OP_FETCH |=> // see RULE2
    code_req_out.valid && code_req_out.addr == $past(pc_r) &&
    pc_r == $past(pc_r) + {14'h0000, $past(req_in.len)})
    else $error("fetch address or step wrong");
  table_addr_a: assert property (idle_go && req_in.op == OP_CODE_TABLE_READ |=> // see RULE5
    code_req_out.valid &&
    code_req_out.addr == $past(req_in.data_pointer) + {8'h00, $past(req_in.acc)})
    else $error("table read address wrong");
  carry_ripple_a: assert property ( // see RULE3
    sum[7:0] == 8'(req_in.data_pointer[7:0] + req_in.acc) &&
    sum[15:8] == 8'(req_in.data_pointer[15:8] +
    {7'h00, (({1'b0, req_in.data_pointer[7:0]} + {1'b0, req_in.acc}) > 9'h0ff)}))
    else $error("address sum lost carry");
  no_acc_write_a: assert property (idle_go && req_in.op == OP_INDIRECT_JUMP |=> // see RULE4
    !acc_valid_out && $stable(acc_out))
    else $error("indirect jump wrote acc");

  // push order: low half one cycle before the high half, control moves with the high half
  call_push_a: assert property (idle_go && req_in.op == OP_LONG_CALL |=> // see RULE7
    ##1 stack_we_out && stack_wdata_out == ret_addr_r[7:0] ##1
    stack_we_out && stack_wdata_out == ret_addr_r[15:8])
    else $error("call push order wrong");
  in_page_call_a: assert property (idle_go && req_in.op == OP_IN_PAGE_CALL |=> // see RULE6
    ##1 stack_we_out && stack_wdata_out == $past(next_pc[7:0], 2) ##1
    stack_we_out && stack_wdata_out == $past(next_pc[15:8], 3))
    else $error("in-page call return address wrong");
  call_target_a: assert property (idle_go && req_in.op == OP_LONG_CALL |=> // see RULE6
    $stable(pc_r) ##1 $stable(pc_r) ##1 pc_r == $past(req_in.target, 3))
    else $error("call transferred control too early");
  busy_call_a: assert property (idle_go && req_in.op == OP_LONG_CALL |=> // see RULE6
    busy_out ##1 busy_out ##1 !busy_out)
    else $error("call busy window wrong");
  push_addr_a: assert property (stack_we_out |-> stack_addr_out == sp_r) // see RULE11
    else $error("push not at the raised stack pointer");

  // pops read the top first, then the byte below it
  pop_order_a: assert property (idle_go && req_in.op == OP_RETURN |=> // see RULE7
    ##1 stack_re_out && stack_addr_out == $past(sp_r, 2) ##1
    stack_re_out && stack_addr_out == $past(sp_r, 3) - 8'h01)
    else $error("return pop order wrong");
  ret_sp_a: assert property (idle_go && req_in.op == OP_RETURN |=> // see RULE11
    ##3 sp_r == $past(sp_r, 4) - 8'h02)
    else $error("return sp not restored");
  page_jump_a: assert property (idle_go && req_in.op == OP_IN_PAGE_JUMP |=> // see RULE12
    pc_r[15:11] == $past(next_pc[15:11]) && pc_r[10:0] == $past(req_in.target[10:0]))
    else $error("in-page jump wrong");
  table_data_a: assert property (idle_go && req_in.op == OP_CODE_TABLE_READ |=> // see RULE5
    !acc_valid_out ##1 !acc_valid_out ##1 acc_valid_out ##1 !acc_valid_out)
    else $error("table read result pulse misplaced");

  // external reads: the narrow pointer never reaches the upper address byte
  xdata8_a: assert property (idle_go && req_in.op == OP_XDATA_READ_8 |=> // see RULE9
    xdata_req_out.valid && xdata_req_out.addr == {8'h00, $past(req_in.ptr8)})
    else $error("8-bit external address too wide");
  xdata16_a: assert property (idle_go && req_in.op == OP_XDATA_READ_16 |=> // see RULE10
    xdata_req_out.valid && xdata_req_out.addr == $past(req_in.data_pointer))
    else $error("16-bit external address wrong");

  call_cover_c: cover property (idle_go && req_in.op == OP_IN_PAGE_CALL);
  ret_cover_c: cover property (state_r == ST_POP_LOAD);
  carry_cover_c: cover property (idle_go && req_in.op == OP_INDIRECT_JUMP &&
    sum[15:8] != req_in.data_pointer[15:8]);
  table_cover_c: cover property (acc_valid_out);
  page_cover_c: cover property (idle_go && req_in.op == OP_IN_PAGE_JUMP &&
    next_pc[15:11] != pc_r[15:11]);
endmodule
